// [pbseq_sequencer.sv]
// Pushbutton on/off power sequencer: debounce, blanking, handshake, lockout.
// Assumes button and kill arrive asynchronously from pins; extensions are
// static configuration on the core clock.
`include "pbseq_cfg.svh"

module pbseq_sequencer #(
    parameter bit EN_ACTIVE_LOW = 1'b0,
    parameter int MS_CYCLES     = `PBSEQ_MS_CYCLES
) (
    // Clock, reset and enable
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     ce,
    // Pins from the outside world
    input  wire logic                     pushbutton_n,
    input  wire logic                     kill_n,
    // Debounce extensions in milliseconds
    input  wire logic [`PBSEQ_EXT_W-1:0]  turn_on_extend,
    input  wire logic [`PBSEQ_EXT_W-1:0]  turn_off_extend,
    // Power control and processor handshake
    output logic                          supply_en,
    output logic                          shutdown_int_n,
    // Status
    output pbseq_pkg::pbseq_status_t      status
);

    // ------------------------------------------------------------------
    // Local constants
    // ------------------------------------------------------------------
    localparam logic EN_ON  = ~EN_ACTIVE_LOW;
    localparam logic EN_OFF = EN_ACTIVE_LOW;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [1:0]                rst_pipe_r;
    logic                      rst_sync_n;
    logic [1:0]                pin_meta_r;
    logic [1:0]                pin_sync_r;
    logic                      pb_low;
    logic                      kill_raw_low;
    logic                      pb_prev_low_r;
    logic                      pb_fall;
    logic [`PBSEQ_KILL_W-1:0]  kill_cnt_r;
    logic                      kill_low_r;
    logic [`PBSEQ_MS_W-1:0]    ms_count;
    logic [`PBSEQ_MS_W-1:0]    on_target;
    logic [`PBSEQ_MS_W-1:0]    off_target;
    logic                      on_done;
    logic                      off_done;
    logic                      blank_done;
    logic                      window_done;
    logic                      lockout_done;
    logic                      release_done;
    logic                      restart;
    logic                      timer_clr;
    pbseq_pkg::pbseq_state_t   state_r;
    pbseq_pkg::pbseq_state_t   state_nxt;
    logic                      supply_en_r;
    logic                      supply_en_nxt;
    logic                      int_n_r;
    logic                      int_n_nxt;
    pbseq_pkg::pbseq_status_t  status_r;
    pbseq_pkg::pbseq_status_t  status_nxt;

    // ------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------

    // Asynchronous assert, release after two clock edges
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_pipe_r <= 2'b00;
        else if (ce)
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
    end

    assign rst_sync_n = rst_pipe_r[1];

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------

    // Two flops per pin; bit 1 is the button, bit 0 is kill
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            pin_meta_r <= `PBSEQ_PIN_IDLE;
            pin_sync_r <= `PBSEQ_PIN_IDLE;
        end
        else if (ce)
        begin
            pin_meta_r <= {pushbutton_n, kill_n};
            pin_sync_r <= pin_meta_r;
        end
    end

    assign pb_low       = ~pin_sync_r[1];
    assign kill_raw_low = ~pin_sync_r[0];

    // ------------------------------------------------------------------
    // Button edge detect
    // ------------------------------------------------------------------

    // Previous synchronised button level, idle is released
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            pb_prev_low_r <= 1'b0;
        else if (ce)
            pb_prev_low_r <= pb_low;
    end

    assign pb_fall = pb_low & ~pb_prev_low_r;

    // ------------------------------------------------------------------
    // Kill glitch filter
    // ------------------------------------------------------------------

    // Kill counts as low only after a continuous low of the minimum width
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            kill_cnt_r <= '0;
            kill_low_r <= 1'b0;
        end
        else if (ce)
        begin
            if (!kill_raw_low)
            begin
                kill_cnt_r <= '0;
                kill_low_r <= 1'b0;
            end
            else if (kill_cnt_r == `PBSEQ_KILL_W'(`PBSEQ_KILL_PW_CYCLES - 1))
                kill_low_r <= 1'b1;
            else
                kill_cnt_r <= kill_cnt_r + `PBSEQ_KILL_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Interval timer
    // ------------------------------------------------------------------

    // Elapsed time restarts on every state change and every debounce restart
    pbseq_timebase #(
        .MS_CYCLES (MS_CYCLES)
    ) u_timebase (
        .clk      (clk),
        .rst_n    (rst_sync_n),
        .ce       (ce),
        .clr      (timer_clr),
        .ms_count (ms_count)
    );

    // Debounce targets are the fixed base plus the programmed extension
    assign on_target  = `PBSEQ_MS_W'(`PBSEQ_BASE_DB_MS)
                      + `PBSEQ_MS_W'(turn_on_extend);
    assign off_target = `PBSEQ_MS_W'(`PBSEQ_BASE_DB_MS)
                      + `PBSEQ_MS_W'(turn_off_extend);

    // Interval completion flags
    assign on_done      = (ms_count >= on_target);
    assign off_done     = (ms_count >= off_target);
    assign blank_done   = (ms_count >= `PBSEQ_MS_W'(`PBSEQ_STARTUP_BLANK_MS));
    assign window_done  = (ms_count >= `PBSEQ_MS_W'(`PBSEQ_POWER_DOWN_MS));
    assign lockout_done = (ms_count >= `PBSEQ_MS_W'(`PBSEQ_LOCKOUT_MS));
    assign release_done = (ms_count >= `PBSEQ_MS_W'(`PBSEQ_BASE_DB_MS));

    // Button bouncing back during a release debounce restarts the count
    always_comb
    begin
        restart = 1'b0;
        unique case (state_r)
            pbseq_pkg::PBSEQ_ON_RELEASE,
            pbseq_pkg::PBSEQ_OFF_RELEASE:
                restart = pb_low;
            default:
                restart = 1'b0;
        endcase
    end

    assign timer_clr = (state_nxt != state_r) | restart;

    // ------------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------------

    // Power state transitions
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            pbseq_pkg::PBSEQ_OFF:
            begin
                if (pb_fall)
                    state_nxt = pbseq_pkg::PBSEQ_ON_DEBOUNCE;
            end
            pbseq_pkg::PBSEQ_ON_DEBOUNCE:
            begin
                if (!pb_low)
                    state_nxt = pbseq_pkg::PBSEQ_OFF;
                else if (on_done)
                    state_nxt = pbseq_pkg::PBSEQ_BLANK;
            end
            pbseq_pkg::PBSEQ_BLANK:
            begin
                // Kill and button are not looked at until blanking ends
                if (blank_done)
                begin
                    if (kill_low_r)
                        state_nxt = pbseq_pkg::PBSEQ_LOCKOUT;
                    else
                        state_nxt = pbseq_pkg::PBSEQ_ON_RELEASE;
                end
            end
            pbseq_pkg::PBSEQ_ON_RELEASE:
            begin
                if (!pb_low && release_done)
                    state_nxt = pbseq_pkg::PBSEQ_RUN;
            end
            pbseq_pkg::PBSEQ_RUN:
            begin
                if (kill_low_r)
                    state_nxt = pbseq_pkg::PBSEQ_LOCKOUT;
                else if (pb_low)
                    state_nxt = pbseq_pkg::PBSEQ_OFF_DEBOUNCE;
            end
            pbseq_pkg::PBSEQ_OFF_DEBOUNCE:
            begin
                if (kill_low_r)
                    state_nxt = pbseq_pkg::PBSEQ_LOCKOUT;
                else if (!pb_low)
                    state_nxt = pbseq_pkg::PBSEQ_RUN;
                else if (off_done)
                    state_nxt = pbseq_pkg::PBSEQ_POWER_DOWN;
            end
            pbseq_pkg::PBSEQ_POWER_DOWN:
            begin
                if (kill_low_r)
                    state_nxt = pbseq_pkg::PBSEQ_LOCKOUT;
                else if (window_done)
                    state_nxt = pbseq_pkg::PBSEQ_OFF_RELEASE;
            end
            pbseq_pkg::PBSEQ_LOCKOUT:
            begin
                if (lockout_done)
                    state_nxt = pbseq_pkg::PBSEQ_OFF_RELEASE;
            end
            pbseq_pkg::PBSEQ_OFF_RELEASE:
            begin
                if (!pb_low && release_done)
                    state_nxt = pbseq_pkg::PBSEQ_OFF;
            end
            default:
                state_nxt = pbseq_pkg::PBSEQ_OFF;
        endcase
    end

    // State register
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            state_r <= pbseq_pkg::PBSEQ_OFF;
        else if (ce)
            state_r <= state_nxt;
    end

    // ------------------------------------------------------------------
    // Output decode
    // ------------------------------------------------------------------

    // Enable, interrupt and status follow the next state
    always_comb
    begin
        supply_en_nxt = EN_OFF;
        int_n_nxt     = 1'b1;
        status_nxt    = '0;
        unique case (state_nxt)
            pbseq_pkg::PBSEQ_BLANK:
            begin
                supply_en_nxt       = EN_ON;
                status_nxt.powered  = 1'b1;
                status_nxt.blanking = 1'b1;
            end
            pbseq_pkg::PBSEQ_ON_RELEASE,
            pbseq_pkg::PBSEQ_RUN,
            pbseq_pkg::PBSEQ_OFF_DEBOUNCE:
            begin
                supply_en_nxt      = EN_ON;
                status_nxt.powered = 1'b1;
            end
            pbseq_pkg::PBSEQ_POWER_DOWN:
            begin
                supply_en_nxt          = EN_ON;
                int_n_nxt              = 1'b0;
                status_nxt.powered     = 1'b1;
                status_nxt.int_pending = 1'b1;
            end
            pbseq_pkg::PBSEQ_LOCKOUT:
            begin
                status_nxt.lockout = 1'b1;
            end
            default:
            begin
                supply_en_nxt = EN_OFF;
            end
        endcase
    end

    // Output registers, converter held off from reset onward
    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            supply_en_r <= EN_OFF;
            int_n_r     <= `PBSEQ_INT_N_RST;
            status_r    <= '0;
        end
        else if (ce)
        begin
            supply_en_r <= supply_en_nxt;
            int_n_r     <= int_n_nxt;
            status_r    <= status_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Port drive
    // ------------------------------------------------------------------
    assign supply_en      = supply_en_r;
    assign shutdown_int_n = int_n_r;
    assign status         = status_r;

endmodule : pbseq_sequencer

// [pbseq_cfg.svh]
// Timing counts and reset values for the pushbutton power sequencer.
// Assumes a 100 MHz core clock and a 1 ms internal timebase tick.
//
// Functional notes
// - After reset the supply enable is inactive, so the converter stays off.
// - Supply enable asserts after button held low 32 ms plus turn-on extension.
// - In the on state, power-off starts after 32 ms plus turn-off extension low.
// - Button going high before debounce ends restarts the debounce timer fully.
// - For 512 ms after enable asserts, kill and button are ignored.
// - Processor raises kill within blanking; kill still low at its end aborts.
// - After blanking, button release is debounced 32 ms before monitoring resumes.
// - Completed turn-off debounce drives the shutdown interrupt low.
// - Interrupt opens a 1024 ms window; at its end enable is released anyway.
// - Kill low during the window releases enable at once and stops the window.
// - In normal on-state operation, kill low releases enable immediately.
// - After kill releases enable, the button is ignored for 256 ms.
// - After shutdown, button release is debounced 32 ms before the off state.
// - In the off state a button high-to-low edge starts a power-on debounce.
// - Build parameter selects active-high or active-low supply enable.
// - Kill low pulses shorter than 30 us are ignored.
// - With zero extensions the debounces are exactly the fixed 32 ms.
`ifndef PBSEQ_CFG_SVH
`define PBSEQ_CFG_SVH

// Clock and timebase
`define PBSEQ_CLK_PERIOD_NS    10
`define PBSEQ_TICK_MS          1
`define PBSEQ_MS_CYCLES        ((`PBSEQ_TICK_MS * 1000000) / `PBSEQ_CLK_PERIOD_NS)

// Fixed intervals in milliseconds, one timebase tick each
`define PBSEQ_BASE_DB_MS       32
`define PBSEQ_STARTUP_BLANK_MS 512
`define PBSEQ_POWER_DOWN_MS    1024
`define PBSEQ_LOCKOUT_MS       256

// Kill input glitch filter
`define PBSEQ_KILL_PW_US       30
`define PBSEQ_KILL_PW_CYCLES   ((`PBSEQ_KILL_PW_US * 1000 + `PBSEQ_CLK_PERIOD_NS - 1) / `PBSEQ_CLK_PERIOD_NS)

// Widths
`define PBSEQ_MS_W             17
`define PBSEQ_PRE_W            17
`define PBSEQ_KILL_W           12
`define PBSEQ_EXT_W            16

// Reset values
`define PBSEQ_INT_N_RST        1'b1
`define PBSEQ_PIN_IDLE         2'b11

`endif

// [pbseq_pkg.sv]
// Types shared by the pushbutton power sequencer.
// Assumes the constants header is included by the design files.
package pbseq_pkg;

    // --------------------------------------------------------------
    // Sequencer states
    // --------------------------------------------------------------
    typedef enum logic [3:0] {
        PBSEQ_OFF,
        PBSEQ_ON_DEBOUNCE,
        PBSEQ_BLANK,
        PBSEQ_ON_RELEASE,
        PBSEQ_RUN,
        PBSEQ_OFF_DEBOUNCE,
        PBSEQ_POWER_DOWN,
        PBSEQ_LOCKOUT,
        PBSEQ_OFF_RELEASE
    } pbseq_state_t;

    // --------------------------------------------------------------
    // Status carried to the user side
    // --------------------------------------------------------------
    typedef struct packed {
        logic powered;
        logic blanking;
        logic int_pending;
        logic lockout;
    } pbseq_status_t;

endpackage : pbseq_pkg

// [pbseq_timebase.sv]
// Millisecond timebase with a restartable elapsed-time counter.
// Assumes a synchronous-release reset and a clock enable from the parent.
`include "pbseq_cfg.svh"

module pbseq_timebase #(
    parameter int MS_CYCLES = `PBSEQ_MS_CYCLES
) (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic                     ce,
    // Control
    input  wire logic                     clr,
    // Elapsed whole milliseconds since the last clear
    output logic [`PBSEQ_MS_W-1:0]        ms_count
);

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    logic [`PBSEQ_PRE_W-1:0] pre_r;
    logic                    tick;

    assign tick = (pre_r == `PBSEQ_PRE_W'(MS_CYCLES - 1));

    // Restart on clear so an interval starts on a whole tick boundary
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pre_r <= '0;
        else if (ce)
        begin
            if (clr || tick)
                pre_r <= '0;
            else
                pre_r <= pre_r + `PBSEQ_PRE_W'(1);
        end
    end

    // ------------------------------------------------------------------
    // Elapsed counter, saturating
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            ms_count <= '0;
        else if (ce)
        begin
            if (clr)
                ms_count <= '0;
            else if (tick && (ms_count != '1))
                ms_count <= ms_count + `PBSEQ_MS_W'(1);
        end
    end

endmodule : pbseq_timebase

// [pbseq_sequencer_sva.sv]
// ------------------------------------------------------------
// Port checker for the pushbutton power sequencer
// ------------------------------------------------------------
// Assumes ce is held high, so every clock counts toward an interval.
`include "pbseq_cfg.svh"
module pbseq_sequencer_chk #(
    parameter bit EN_ACTIVE_LOW = 1'b0,
    parameter int MS_CYCLES     = `PBSEQ_MS_CYCLES
) (
    // Clock and reset
    input wire logic                     clk,
    input wire logic                     rst_n,
    input wire logic                     ce,
    // Pins and extensions
    input wire logic                     pushbutton_n,
    input wire logic                     kill_n,
    input wire logic [`PBSEQ_EXT_W-1:0]  turn_on_extend,
    input wire logic [`PBSEQ_EXT_W-1:0]  turn_off_extend,
    // Outputs
    input wire logic                     supply_en,
    input wire logic                     shutdown_int_n,
    input wire pbseq_pkg::pbseq_status_t status
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int KILL_CYC = `PBSEQ_KILL_PW_CYCLES;
    logic en_on;
    int   pb_lo, kill_lo, int_lo, lock_n, blank_n;
    assign en_on = supply_en ^ EN_ACTIVE_LOW;
    // Run lengths of the conditions that the intervals rest on
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pb_lo   <= 0;
            kill_lo <= 0;
            int_lo  <= 0;
            lock_n  <= 0;
            blank_n <= 0;
        end
        else
        begin
            pb_lo   <= pushbutton_n ? 0 : pb_lo + 1;
            kill_lo <= kill_n ? 0 : kill_lo + 1;
            int_lo  <= shutdown_int_n ? 0 : int_lo + 1;
            lock_n  <= status.lockout ? lock_n + 1 : 0;
            blank_n <= status.blanking ? blank_n + 1 : 0;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    reset_quiet_a: assert property ($rose(rst_n) |-> !en_on && shutdown_int_n && status == 4'h0)
        else $error("outputs active after reset");
    on_debounce_a: assert property ($rose(en_on) |-> pb_lo >= (32 + int'(turn_on_extend)) * MS_CYCLES)
        else $error("enable before on debounce");
    off_debounce_a: assert property ($fell(shutdown_int_n) |-> pb_lo >= (32 + int'(turn_off_extend)) * MS_CYCLES)
        else $error("interrupt before off debounce");
    blank_flag_a: assert property ($rose(en_on) |-> ##[1:3] status.blanking)
        else $error("no blanking after enable");
    blank_hold_a: assert property (status.blanking |-> en_on && shutdown_int_n)
        else $error("activity during blanking");
    blank_len_a: assert property ($fell(status.blanking) |-> blank_n >= 512 * MS_CYCLES)
        else $error("blanking too short");
    window_len_a: assert property (int_lo <= 1024 * MS_CYCLES + 4)
        else $error("power down window too long");
    int_release_a: assert property ($rose(shutdown_int_n) |-> !en_on)
        else $error("interrupt cleared with enable on");
    kill_filter_a: assert property ($fell(en_on) && $past(shutdown_int_n) |-> kill_lo >= KILL_CYC)
        else $error("release on short kill pulse");
    lock_enter_a: assert property ($fell(en_on) && $past(shutdown_int_n) |-> ##[0:2] status.lockout)
        else $error("no lockout after kill release");
    lock_len_a: assert property ($fell(status.lockout) |-> lock_n >= 256 * MS_CYCLES)
        else $error("lockout too short");
    // Main scenarios
    cover property ($rose(en_on));
    cover property ($fell(shutdown_int_n));
    cover property ($rose(status.lockout));
endmodule : pbseq_sequencer_chk

bind pbseq_sequencer pbseq_sequencer_chk #(.EN_ACTIVE_LOW(EN_ACTIVE_LOW), .MS_CYCLES(MS_CYCLES))
    u_chk (.clk(clk), .rst_n(rst_n), .ce(ce), .pushbutton_n(pushbutton_n), .kill_n(kill_n),
           .turn_on_extend(turn_on_extend), .turn_off_extend(turn_off_extend),
           .supply_en(supply_en), .shutdown_int_n(shutdown_int_n), .status(status));

// [pbseq_host_model.sv]
// Processor model on the kill/interrupt handshake.
// Assumes powered is the active-high supply enable.
module pbseq_host_model (
    // Clock
    input wire logic  clk,
    // Device side
    input wire logic  powered,
    input wire logic  int_n,
    // Scenario controls
    input wire logic  raise_ok,
    input wire logic  ack_ok,
    input wire logic  drop_req,
    output logic      kill_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int boot_cnt = 0;
    // Unpowered holds kill low; slow boot raises it inside blanking
    always @(posedge clk)
    begin
        boot_cnt <= powered ? boot_cnt + 1 : 0;
        if (!powered)
            kill_n <= 1'b0;
        // With ack_ok set, kill follows the interrupt as a tied board would
        else if (drop_req || (ack_ok && !int_n))
            kill_n <= 1'b0;
        else if (raise_ok && boot_cnt > 2000)
            kill_n <= 1'b1;
    end
endmodule : pbseq_host_model

// [test_pbseq_sequencer.sv]
// Self-checking bench for the pushbutton power sequencer.
// Assumes 100 MHz clock, a 10-cycle millisecond and ce held high except during the frozen-press check.
`include "pbseq_cfg.svh"
module test_pbseq_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 10;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, pb_n = 1'b1;
    logic raise_ok = 1'b1, ack_ok = 1'b1, drop_req = 1'b0;
    logic [`PBSEQ_EXT_W-1:0] ext_on = '0, ext_off = '0;
    logic kill_n, supply_en, supply_en_lo, shutdown_int_n;
    pbseq_pkg::pbseq_status_t status;
    int mismatches = 0, checks_done = 0;

    // Devices under test: active-high and active-low builds
    pbseq_sequencer #(.EN_ACTIVE_LOW(1'b0), .MS_CYCLES(T)) dut (.clk(clk), .rst_n(rst_n),
        .ce(ce), .pushbutton_n(pb_n), .kill_n(kill_n), .turn_on_extend(ext_on),
        .turn_off_extend(ext_off), .supply_en(supply_en), .shutdown_int_n(shutdown_int_n),
        .status(status));
    pbseq_sequencer #(.EN_ACTIVE_LOW(1'b1), .MS_CYCLES(T)) dut_lo (.clk(clk), .rst_n(rst_n),
        .ce(ce), .pushbutton_n(pb_n), .kill_n(kill_n), .turn_on_extend(ext_on),
        .turn_off_extend(ext_off), .supply_en(supply_en_lo), .shutdown_int_n(),
        .status());
    pbseq_host_model host (.clk(clk), .powered(supply_en), .int_n(shutdown_int_n),
        .raise_ok(raise_ok), .ack_ok(ack_ok), .drop_req(drop_req), .kill_n(kill_n));

    // Clock
    initial
    begin
        forever #5 clk = ~clk;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    // Bounded wait: 0 enable, 1 interrupt, 2 blanking, 3 lockout
    task automatic wait_sig(input int sel, input logic want, input int lim, output int n);
        logic v;
        n = 0;
        forever
        begin
            @(posedge clk);
            #1;
            v = sel == 0 ? supply_en : sel == 1 ? shutdown_int_n :
                sel == 2 ? status.blanking : status.lockout;
            if (v === want)
                return;
            n++;
            if (n > lim)
            begin
                mismatches++;
                $display("[FAIL] wait %0d expected %0h seen %0h", sel, want, v);
                give_verdict();
            end
        end
    endtask : wait_sig

    task automatic t_bounce();
        @(posedge clk);
        pb_n <= 1'b0;
        repeat (20 * T) @(posedge clk);
        pb_n <= 1'b1;
        repeat (3) @(posedge clk);
        pb_n <= 1'b0;
        repeat (20 * T) @(posedge clk);
        pb_n <= 1'b1;
        repeat (20 * T) @(posedge clk);
        check("bounced press", supply_en, 1'b0);
        // A long press while the clock enable is low must not be seen
        ce <= 1'b0;
        pb_n <= 1'b0;
        repeat (40 * T) @(posedge clk);
        pb_n <= 1'b1;
        repeat (5) @(posedge clk);
        ce <= 1'b1;
        repeat (40 * T) @(posedge clk);
        check("frozen press", supply_en, 1'b0);
    endtask : t_bounce

    task automatic power_on(input logic [15:0] ext);
        int n;
        @(posedge clk);
        ext_on <= ext;
        @(posedge clk);
        pb_n <= 1'b0;
        wait_sig(0, 1'b1, (40 + ext) * T, n);
        check("on delay min", n >= (32 + ext) * T, 1'b1);
        check("on delay max", n <= (32 + ext) * T + 8, 1'b1);
        check("low-true copy", supply_en_lo, 1'b0);
        wait_sig(2, 1'b1, 4, n);
        check("blank status", status, 4'hc);
        wait_sig(2, 1'b0, 520 * T, n);
        check("blank length", n >= 510 * T, 1'b1);
        @(posedge clk);
        pb_n <= 1'b1;
        repeat (40 * T) @(posedge clk);
    endtask : power_on

    task automatic t_turn_off(input logic [15:0] ext, input logic ack);
        int n;
        @(posedge clk);
        ext_off <= ext;
        ack_ok <= ack;
        @(posedge clk);
        pb_n <= 1'b0;
        wait_sig(1, 1'b0, (40 + ext) * T, n);
        check("off delay", n >= (32 + ext) * T, 1'b1);
        check("on at interrupt", supply_en, 1'b1);
        check("pending status", status, 4'ha);
        @(posedge clk);
        pb_n <= 1'b1;
        wait_sig(0, 1'b0, 1030 * T, n);
        check("interrupt cleared", shutdown_int_n, 1'b1);
        if (ack)
        begin
            check("ack release", n <= 3012, 1'b1);
            wait_sig(3, 1'b1, 4, n);
            @(posedge clk);
            pb_n <= 1'b0;
            repeat (100 * T) @(posedge clk);
            pb_n <= 1'b1;
        end
        else
        begin
            check("window length", n >= 1022 * T, 1'b1);
            repeat (3) @(posedge clk);
            check("no lockout", status.lockout, 1'b0);
        end
        repeat (300 * T) @(posedge clk);
        check("off after shutdown", supply_en, 1'b0);
        check("low-true off", supply_en_lo, 1'b1);
    endtask : t_turn_off

    task automatic t_kill(input int len, input logic exp_on);
        int n;
        @(posedge clk);
        drop_req <= 1'b1;
        repeat (len) @(posedge clk);
        drop_req <= 1'b0;
        check("kill result", supply_en, exp_on);
        if (!exp_on)
        begin
            wait_sig(3, 1'b1, 4, n);
            repeat (300 * T) @(posedge clk);
        end
    endtask : t_kill

    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        check("reset enable", supply_en, 1'b0);
        check("reset interrupt", shutdown_int_n, 1'b1);
        check("reset status", status, 4'h0);
        t_bounce();
        power_on(16'h0000);
        t_kill(1000, 1'b1);
        t_turn_off(16'h0003, 1'b1);
        power_on(16'h0005);
        t_turn_off(16'h0000, 1'b0);
        raise_ok <= 1'b0;
        power_on(16'h0000);
        check("abort", supply_en, 1'b0);
        check("abort lockout", status.lockout, 1'b1);
        repeat (300 * T) @(posedge clk);
        raise_ok <= 1'b1;
        power_on(16'h0000);
        t_kill(3020, 1'b0);
        give_verdict();
    end
endmodule : test_pbseq_sequencer
